// ---- hdl/timer_chan_pkg.sv ----
// Functional notes
// - Center select clear and mode bit B set gives edge-aligned PWM, ignoring mode bit A.
// - Center select and mode bit B clear: mode bit A picks capture (0) or compare (1).
// - Edge/level field zero releases the pin; compare then is software compare only.
// - Capture edge: 01 rising only, 10 falling only, 11 either edge.
// - Compare match action: 00 none, 01 toggle, 10 drive low, 11 drive high.
// - Edge PWM: 10 gives high-true pulses cleared on match; X1 gives low-true pulses.
// - Center PWM: 10 clears on up-count match; X1 sets on up-count match.
// - Reset clears both bytes of the channel value.
// - Capture mode: reading either byte latches both; other byte comes from that buffer.
// - Any control/status write resets read and write byte latches, debug or not.
// - Capture mode ignores all software writes to the value bytes.
// - Debug mode freezes read latches even across reads, unless control is written.
// - Debug mode value reads return live register contents, not the buffer.
// - Compare/PWM byte writes go to a buffer; both bytes then move as one word.
// - Clock select zero updates the value immediately on the second byte write.
// - Clock selected, compare mode: buffered value moves at the next counter increment.
// - Clock selected, PWM: move on modulo-1 to modulo, or FFFE to FFFF free-running.
// - Debug byte writes go straight to the value and govern later compare/PWM.
// - Debug writes leave a partial buffered sequence intact for completion afterwards.
// - Global center select forces center PWM on all channels; clear means per-channel.
// - The two-bit counter clock select clears on reset, stopping the counter.
package timer_chan_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses of aligned words
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_VAL_HI    = 8'h04;
  localparam logic [7:0]  OFS_VAL_LO    = 8'h08;
  localparam logic [7:0]  OFS_GLOBAL    = 8'h0C;

  // Field positions
  localparam int          CTRL_LSB      = 2;
  localparam int          CTRL_MSB      = 5;
  localparam int          CAS_BIT       = 0;
  localparam int          CLKS_LSB      = 1;
  localparam int          CLKS_MSB      = 2;

  // Reset values
  localparam logic [3:0]  CTRL_RST      = 4'h0;
  localparam logic [15:0] VALUE_RST     = 16'h0000;
  localparam logic [1:0]  CLKS_RST      = 2'h0;
  localparam logic        CAS_RST       = 1'b0;

  // Counter landmarks
  localparam logic [15:0] FREE_PRE_TOP  = 16'hFFFE;
  localparam logic [15:0] FREE_TOP      = 16'hFFFF;
  localparam logic [15:0] MOD_FREE      = 16'h0000;
  localparam logic [15:0] ONE_16        = 16'h0001;

  // Edge/level encodings
  localparam logic [1:0]  ELS_NONE      = 2'h0;
  localparam logic [1:0]  ELS_TOGGLE    = 2'h1;
  localparam logic [1:0]  ELS_CLEAR     = 2'h2;
  localparam logic [1:0]  ELS_SET       = 2'h3;

  // AHB-Lite codes
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
  localparam logic        HRESP_OKAY    = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    MODE_CAPTURE    = 2'b00,
    MODE_COMPARE    = 2'b01,
    MODE_EDGE_PWM   = 2'b11,
    MODE_CENTER_PWM = 2'b10
  } chan_mode_e;

  typedef struct packed {
    logic mode_select_b;
    logic mode_select_a;
    logic edge_level_sel_hi;
    logic edge_level_sel_lo;
  } chan_ctrl_s;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } bus_phase_s;

endpackage

// ---- hdl/timer_channel_mode_and_value.sv ----
// Added by the designer: the placing of the registers and the AHB-Lite register port.
module timer_channel_mode_and_value
  import timer_chan_pkg::*;
(
  input  wire logic        clk_sys_i,               // System clock, 125 MHz
  input  wire logic        rst_n_i,                 // Synchronous reset, active low
  input  wire logic        hsel_i,                  // AHB slave select
  input  wire logic [31:0] haddr_i,                 // AHB address
  input  wire logic [1:0]  htrans_i,                // AHB transfer type
  input  wire logic        hwrite_i,                // AHB write
  input  wire logic [2:0]  hsize_i,                 // AHB size
  input  wire logic [31:0] hwdata_i,                // AHB write data
  input  wire logic        hready_i,                // AHB bus ready
  output logic      [31:0] hrdata_o,                // AHB read data
  output logic             hreadyout_o,             // AHB slave ready
  output logic             hresp_o,                 // AHB response, always OKAY
  input  wire logic [15:0] count_i,                 // Shared counter value
  input  wire logic [15:0] modulo_i,                // Active modulo value
  input  wire logic        count_tick_i,            // Counter advances at this edge
  input  wire logic        count_up_i,              // Counter direction, high = up
  input  wire logic        debug_mode_i,            // Debug halt active
  input  wire logic        pin_i,                   // Channel pin level
  output logic             pin_o,                   // Channel pin drive value
  output logic             pin_oe_o,                // Channel pin owned by timer
  output logic      [1:0]  clock_select_o,          // Counter clock select to counter
  output logic             center_aligned_select_o, // Global center select to counter
  output logic             match_o,                 // Compare match pulse
  output logic             capture_o                // Capture event pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding
  function automatic chan_mode_e decode_mode(input logic cas, input chan_ctrl_s c);
    if (cas)
      return MODE_CENTER_PWM;
    else if (c.mode_select_b)
      return MODE_EDGE_PWM;
    else if (c.mode_select_a)
      return MODE_COMPARE;
    else
      return MODE_CAPTURE;
  endfunction

  function automatic logic [15:0] put_byte(input logic [15:0] w, input logic hi, input logic [7:0] b);
    return hi ? {b, w[7:0]} : {w[15:8], b};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  chan_ctrl_s  ctrl_reg,       ctrl_next;
  logic        cas_reg,        cas_next;
  logic [1:0]  clks_reg,       clks_next;
  logic [15:0] value_reg,      value_next;
  logic [15:0] rd_buf_reg,     rd_buf_next;
  logic        rd_latched_reg, rd_latched_next;
  logic [15:0] wr_buf_reg,     wr_buf_next;
  logic        wr_hi_done_reg, wr_hi_done_next;
  logic        wr_lo_done_reg, wr_lo_done_next;
  logic        pend_reg,       pend_next;
  logic        pin_prev_reg;
  logic        out_reg,        out_next;
  logic        match_reg;
  logic        capture_reg;
  bus_phase_s  dp_reg,         dp_next;
  logic        rd_done_reg;
  logic [31:0] hrdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes take no wait state, reads one
  wire addr_take   = hsel_i && htrans_i[1] && hready_i && (hsize_i == HSIZE_WORD);
  wire dp_rd       = dp_reg.valid && !dp_reg.write;
  wire rd_strobe   = dp_rd && !rd_done_reg;
  wire wr_strobe   = dp_reg.valid && dp_reg.write;
  wire wr_ctrl     = wr_strobe && (dp_reg.addr == OFS_CTRL);
  wire wr_global   = wr_strobe && (dp_reg.addr == OFS_GLOBAL);
  wire wv_hi       = wr_strobe && (dp_reg.addr == OFS_VAL_HI);
  wire wv_lo       = wr_strobe && (dp_reg.addr == OFS_VAL_LO);
  wire rd_val      = rd_strobe && ((dp_reg.addr == OFS_VAL_HI) || (dp_reg.addr == OFS_VAL_LO));
  wire [7:0] wbyte = hwdata_i[7:0];

  assign dp_next     = hready_i ? '{valid: addr_take, write: hwrite_i, addr: haddr_i[7:0]} : dp_reg;
  assign hreadyout_o = !rd_strobe;
  assign hresp_o     = HRESP_OKAY;
  assign hrdata_o    = hrdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and counter landmarks
  wire chan_mode_e mode = decode_mode(cas_reg, ctrl_reg);
  wire [1:0]  els       = {ctrl_reg.edge_level_sel_hi, ctrl_reg.edge_level_sel_lo};
  wire        is_pwm    = (mode == MODE_EDGE_PWM) || (mode == MODE_CENTER_PWM);
  wire        wr_ok     = (mode != MODE_CAPTURE);
  wire [15:0] top       = (modulo_i == MOD_FREE) ? FREE_TOP : modulo_i;
  wire [15:0] pre_top   = (modulo_i == MOD_FREE) ? FREE_PRE_TOP : modulo_i - ONE_16;
  wire        period_end = count_tick_i && (count_i == top);

  ////////////////////////////////////////////////////////////////////////////
  // Read path; debug reads show the live value
  wire        use_buf  = rd_latched_reg && !debug_mode_i;
  wire [15:0] val_view = use_buf ? rd_buf_reg : value_reg;
  wire [31:0] rd_mux   = (dp_reg.addr == OFS_CTRL)   ? {26'h0, ctrl_reg, 2'h0} :
                         (dp_reg.addr == OFS_GLOBAL) ? {29'h0, clks_reg, cas_reg} :
                         (dp_reg.addr == OFS_VAL_HI) ? {24'h0, val_view[15:8]} :
                         (dp_reg.addr == OFS_VAL_LO) ? {24'h0, val_view[7:0]} : 32'h0;

  // First value read latches both bytes, the second read drains the buffer
  wire rd_step = rd_val && (mode == MODE_CAPTURE) && !debug_mode_i;
  assign rd_latched_next = wr_ctrl ? 1'b0 : (rd_step ? !rd_latched_reg : rd_latched_reg);
  assign rd_buf_next     = (rd_step && !rd_latched_reg) ? value_reg : rd_buf_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Write coherency; debug writes bypass and leave the sequence alone
  wire buf_write = wr_ok && !debug_mode_i && (wv_hi || wv_lo);
  wire dbg_write = wr_ok && debug_mode_i && (wv_hi || wv_lo);
  wire hi_after  = wr_hi_done_reg || wv_hi;
  wire lo_after  = wr_lo_done_reg || wv_lo;
  wire pair_done = buf_write && hi_after && lo_after;
  wire clk_off   = (clks_reg == CLKS_RST);
  // A down-count pass of the landmark in center PWM is not a period boundary
  wire upd_point = (mode == MODE_COMPARE) ? count_tick_i :
                   (is_pwm && count_tick_i && (count_i == pre_top) &&
                    (count_up_i || (mode == MODE_EDGE_PWM)));
  wire xfer      = pend_reg && !pair_done && upd_point && !debug_mode_i;

  assign wr_buf_next     = buf_write ? put_byte(wr_buf_reg, wv_hi, wbyte) : wr_buf_reg;
  assign wr_hi_done_next = (wr_ctrl || pair_done) ? 1'b0 : (buf_write ? hi_after : wr_hi_done_reg);
  assign wr_lo_done_next = (wr_ctrl || pair_done) ? 1'b0 : (buf_write ? lo_after : wr_lo_done_reg);
  assign pend_next       = wr_ctrl ? 1'b0 : (pair_done && !clk_off) ? 1'b1 : (xfer ? 1'b0 : pend_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Capture edge selection
  wire rise    = pin_i && !pin_prev_reg;
  wire fall    = !pin_i && pin_prev_reg;
  wire cap_evt = (mode == MODE_CAPTURE) &&
                 ((ctrl_reg.edge_level_sel_lo && rise) || (ctrl_reg.edge_level_sel_hi && fall));

  // Capture wins over everything; capture mode never has a write path
  assign value_next = cap_evt               ? count_i :
                      dbg_write             ? put_byte(value_reg, wv_hi, wbyte) :
                      (pair_done && clk_off) ? wr_buf_next :
                      xfer                  ? wr_buf_reg : value_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin behaviour; a match is the end of the count equal to the value
  wire match_w   = wr_ok && count_tick_i && (count_i == value_reg);
  wire high_true = (els == ELS_CLEAR);

  always_comb
  begin
    out_next = out_reg;
    case (mode)
      MODE_COMPARE:
      begin
        if (match_w)
        begin
          case (els)
            ELS_TOGGLE: out_next = !out_reg;
            ELS_CLEAR:  out_next = 1'b0;
            ELS_SET:    out_next = 1'b1;
            default:    out_next = out_reg;
          endcase
        end
      end
      MODE_EDGE_PWM:
      begin
        if (period_end)
          out_next = high_true;
        else if (match_w)
          out_next = !high_true;
      end
      MODE_CENTER_PWM:
      begin
        // Down-count match drives the active level of the pulse
        if (match_w)
          out_next = count_up_i ? !high_true : high_true;
      end
      default:
        out_next = out_reg;
    endcase
  end

  // Capture only listens, so the timer never drives the pin there
  assign pin_oe_o                = (els != ELS_NONE) && (mode != MODE_CAPTURE);
  assign pin_o                   = out_reg;
  assign match_o                 = match_reg;
  assign capture_o               = capture_reg;
  assign clock_select_o          = clks_reg;
  assign center_aligned_select_o = cas_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  assign ctrl_next = wr_ctrl   ? chan_ctrl_s'(hwdata_i[CTRL_MSB:CTRL_LSB]) : ctrl_reg;
  assign cas_next  = wr_global ? hwdata_i[CAS_BIT] : cas_reg;
  assign clks_next = wr_global ? hwdata_i[CLKS_MSB:CLKS_LSB] : clks_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Flip-flops
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_reg   <= chan_ctrl_s'(CTRL_RST);
      cas_reg    <= CAS_RST;
      clks_reg   <= CLKS_RST;
      value_reg  <= VALUE_RST;
      dp_reg     <= '0;
    end
    else
    begin
      ctrl_reg   <= ctrl_next;
      cas_reg    <= cas_next;
      clks_reg   <= clks_next;
      value_reg  <= value_next;
      dp_reg     <= dp_next;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      rd_buf_reg     <= VALUE_RST;
      rd_latched_reg <= 1'b0;
      wr_buf_reg     <= VALUE_RST;
      wr_hi_done_reg <= 1'b0;
      wr_lo_done_reg <= 1'b0;
      pend_reg       <= 1'b0;
    end
    else
    begin
      rd_buf_reg     <= rd_buf_next;
      rd_latched_reg <= rd_latched_next;
      wr_buf_reg     <= wr_buf_next;
      wr_hi_done_reg <= wr_hi_done_next;
      wr_lo_done_reg <= wr_lo_done_next;
      pend_reg       <= pend_next;
    end
  end

  // Edge history runs in every mode so a mode change cannot see a stale level
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      pin_prev_reg <= 1'b0;
      out_reg      <= 1'b0;
      match_reg    <= 1'b0;
      capture_reg  <= 1'b0;
      rd_done_reg  <= 1'b0;
      hrdata_reg   <= 32'h0;
    end
    else
    begin
      pin_prev_reg <= pin_i;
      out_reg      <= out_next;
      match_reg    <= match_w;
      capture_reg  <= cap_evt;
      rd_done_reg  <= rd_strobe;
      hrdata_reg   <= rd_strobe ? rd_mux : hrdata_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_edge_pwm_sel;
    !cas_reg && ctrl_reg.mode_select_b && (els == ELS_CLEAR) && count_tick_i && (count_i == top)
      |=> pin_o;
  endproperty
  a_edge_pwm_sel: assert property (p_edge_pwm_sel) else $error("edge PWM period start missing");

  property p_cap_cmp_sel;
    !cas_reg && !ctrl_reg.mode_select_b && count_tick_i && (count_i == value_reg)
      |=> match_o == $past(ctrl_reg.mode_select_a);
  endproperty
  a_cap_cmp_sel: assert property (p_cap_cmp_sel) else $error("capture/compare select wrong");

  property p_pin_release;
    wr_ctrl && (hwdata_i[CTRL_LSB+1:CTRL_LSB] == ELS_NONE) |=> !pin_oe_o;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("pin not released");

  property p_capture_value;
    (mode == MODE_CAPTURE) && ctrl_reg.edge_level_sel_lo && !pin_prev_reg && pin_i
      |=> value_reg == $past(count_i) ##0 capture_o;
  endproperty
  a_capture_value: assert property (p_capture_value) else $error("rising edge not captured");

  property p_toggle;
    (mode == MODE_COMPARE) && (els == ELS_TOGGLE) && count_tick_i && (count_i == value_reg)
      |=> pin_o != $past(out_reg);
  endproperty
  a_toggle: assert property (p_toggle) else $error("compare toggle missing");

  property p_reset_clear;
    disable iff (1'b0)
    !rst_n_i |=> (value_reg == VALUE_RST) && (clks_reg == CLKS_RST);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear value");

  property p_ctrl_unlatch;
    wr_ctrl |=> !rd_latched_reg && !wr_hi_done_reg && !wr_lo_done_reg && !pend_reg;
  endproperty
  a_ctrl_unlatch: assert property (p_ctrl_unlatch) else $error("control write kept latches");

  property p_cap_write_ignored;
    (mode == MODE_CAPTURE) && (wv_hi || wv_lo) && !cap_evt |=> $stable(value_reg);
  endproperty
  a_cap_write_ignored: assert property (p_cap_write_ignored) else $error("capture value written");

  property p_debug_freeze;
    debug_mode_i && !wr_ctrl |=> $stable(rd_latched_reg) && $stable(wr_hi_done_reg);
  endproperty
  a_debug_freeze: assert property (p_debug_freeze) else $error("latches moved in debug");

  property p_immediate;
    pair_done && clk_off && !cap_evt |=> value_reg == $past(wr_buf_next) ##1 $stable(wr_buf_reg)[*1];
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate update missing");

  property p_edge_low_true;
    (mode == MODE_EDGE_PWM) && ctrl_reg.edge_level_sel_lo && match_w && !period_end
      |=> pin_o;
  endproperty
  a_edge_low_true: assert property (p_edge_low_true) else $error("low-true pulse not set on match");

  property p_center_up;
    cas_reg && (els != ELS_NONE) && count_up_i && count_tick_i && (count_i == value_reg)
      |=> pin_o == $past(ctrl_reg.edge_level_sel_lo);
  endproperty
  a_center_up: assert property (p_center_up) else $error("center PWM up-count match wrong");

  property p_debug_live_read;
    rd_strobe && debug_mode_i && (dp_reg.addr == OFS_VAL_LO)
      |=> hrdata_o[7:0] == $past(value_reg[7:0]);
  endproperty
  a_debug_live_read: assert property (p_debug_live_read) else $error("debug read not live");

  property p_clocked_hold;
    pair_done && !clk_off |=> $stable(value_reg);
  endproperty
  a_clocked_hold: assert property (p_clocked_hold) else $error("clocked update not deferred");

  property p_debug_write;
    dbg_write && wv_lo |=> value_reg[7:0] == $past(wbyte);
  endproperty
  a_debug_write: assert property (p_debug_write) else $error("debug write not direct");

endmodule

// ---- testbench/timer_channel_mode_and_value_tb_top.sv ----
module timer_channel_mode_and_value_tb_top;
  import timer_chan_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = HSIZE_WORD;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [15:0] count = 16'h0000;
  logic [15:0] modulo = 16'h0000;
  logic        tick_en = 1'b0;
  logic        count_up = 1'b1;
  logic        debug = 1'b0;
  logic        ext_level = 1'b0;
  logic        pin_level, pin_o, pin_oe, match, capture, cas;
  logic [1:0]  clks;
  logic        rdy_s;
  logic [31:0] rd_s;
  logic        hresp;
  logic        m;
  int          failures = 0;
  int          n_tests = 0;
  int          cycles = 0;

  always #4 clk_sys = ~clk_sys;

  timer_channel_mode_and_value dut (
    .clk_sys_i(clk_sys), .rst_n_i(rst_n), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .count_i(count), .modulo_i(modulo), .count_tick_i(tick_en), .count_up_i(count_up),
    .debug_mode_i(debug), .pin_i(pin_level), .pin_o(pin_o), .pin_oe_o(pin_oe),
    .clock_select_o(clks), .center_aligned_select_o(cas), .match_o(match),
    .capture_o(capture));

  timer_pin_model pin_model (
    .level_req_i(ext_level), .timer_drv_i(pin_o), .timer_oe_i(pin_oe),
    .pin_level_o(pin_level));

  // Bus outputs as they stand at the coming rising edge
  always @(negedge clk_sys)
  begin
    rdy_s = hreadyout;
    rd_s = hrdata;
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      give_verdict();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hwrite <= wr;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    @(posedge clk_sys);
    while (rdy_s !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_sys);
    while (rdy_s !== 1'b1) @(posedge clk_sys);
    rd = rd_s;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    bus(1'b0, a, 32'h00000000, d);
    chk(what, {24'h000000, e}, d);
  endtask

  function automatic logic [31:0] ctl(input logic [3:0] c);
    return {28'h0000000, c} << CTRL_LSB;
  endfunction

  task automatic tick(input logic [15:0] c, input logic up);
    count <= c;
    count_up <= up;
    tick_en <= 1'b1;
    @(posedge clk_sys);
    tick_en <= 1'b0;
    @(negedge clk_sys);
    m = match;
    @(posedge clk_sys);
  endtask

  task automatic pin_is(input logic e);
    @(negedge clk_sys);
    chk("pin", {31'h0, e}, {31'h0, pin_level});
    @(posedge clk_sys);
  endtask

  task automatic edge_in(input logic lvl, input logic [15:0] c, input logic e);
    count <= c;
    ext_level <= lvl;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("capture", {31'h0, e}, {31'h0, capture});
    @(posedge clk_sys);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd("val_hi", OFS_VAL_HI, 8'h00);
    rd("val_lo", OFS_VAL_LO, 8'h00);
    rd("global", OFS_GLOBAL, 8'h00);
    chk("clks", 32'h0, {30'h0, clks});
    chk("hresp", 32'h0, {31'h0, hresp});
    $display("reset test done");
  endtask

  task automatic t_capture();
    for (int f = 1; f < 4; f++)
    begin
      wr(OFS_CTRL, ctl(4'(f)));
      repeat (3) @(posedge clk_sys);
      edge_in(1'b1, 16'h0000, f[0]);
      edge_in(1'b0, 16'h0000, f[1]);
    end
    wr(OFS_CTRL, ctl(4'h1));
    edge_in(1'b1, 16'h1234, 1'b1);
    rd("cap_hi", OFS_VAL_HI, 8'h12);
    edge_in(1'b0, 16'hABCD, 1'b0);
    edge_in(1'b1, 16'hABCD, 1'b1);
    rd("buf_lo", OFS_VAL_LO, 8'h34);
    wr(OFS_VAL_HI, 32'h000000FF);
    rd("cap_hi", OFS_VAL_HI, 8'hAB);
    edge_in(1'b0, 16'h1111, 1'b0);
    edge_in(1'b1, 16'h1111, 1'b1);
    wr(OFS_CTRL, ctl(4'h1));
    rd("live_lo", OFS_VAL_LO, 8'h11);
    debug <= 1'b1;
    rd("dbg_hi", OFS_VAL_HI, 8'h11);
    edge_in(1'b0, 16'h2222, 1'b0);
    edge_in(1'b1, 16'h2222, 1'b1);
    rd("dbg_lo", OFS_VAL_LO, 8'h22);
    debug <= 1'b0;
    rd("after_dbg", OFS_VAL_HI, 8'h11);
    $display("capture test done");
  endtask

  task automatic t_compare();
    logic [1:0] fld [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
    logic       exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr(OFS_CTRL, ctl(4'h7));
    wr(OFS_VAL_HI, 32'h00000000);
    rd("buffered", OFS_VAL_HI, 8'h22);
    wr(OFS_VAL_LO, 32'h00000010);
    rd("pair_hi", OFS_VAL_HI, 8'h00);
    rd("pair_lo", OFS_VAL_LO, 8'h10);
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_CTRL, ctl({2'b01, fld[i]}));
      tick(16'h0010, 1'b1);
      chk("oe", 32'h1, {31'h0, pin_oe});
      chk("match", 32'h1, {31'h0, m});
      pin_is(exp[i]);
    end
    tick(16'h000F, 1'b1);
    chk("no_match", 32'h0, {31'h0, m});
    wr(OFS_CTRL, ctl(4'h4));
    tick(16'h0010, 1'b1);
    chk("oe_off", 32'h0, {31'h0, pin_oe});
    chk("sw_match", 32'h1, {31'h0, m});
    $display("compare test done");
  endtask

  task automatic t_debug();
    wr(OFS_VAL_HI, 32'h00000022);
    debug <= 1'b1;
    wr(OFS_VAL_LO, 32'h00000033);
    rd("dbg_lo", OFS_VAL_LO, 8'h33);
    rd("dbg_hi", OFS_VAL_HI, 8'h00);
    debug <= 1'b0;
    wr(OFS_VAL_LO, 32'h00000044);
    rd("done_hi", OFS_VAL_HI, 8'h22);
    rd("done_lo", OFS_VAL_LO, 8'h44);
    $display("debug test done");
  endtask

  task automatic t_clocked();
    wr(OFS_GLOBAL, 32'h00000002);
    wr(OFS_CTRL, ctl(4'h7));
    chk("clks", 32'h1, {30'h0, clks});
    wr(OFS_VAL_HI, 32'h00000001);
    wr(OFS_VAL_LO, 32'h00000002);
    rd("held", OFS_VAL_LO, 8'h44);
    tick(16'h0000, 1'b1);
    rd("moved", OFS_VAL_LO, 8'h02);
    $display("clocked update test done");
  endtask

  task automatic t_pwm();
    modulo <= 16'h0010;
    wr(OFS_CTRL, ctl(4'hE));
    wr(OFS_VAL_HI, 32'h00000000);
    wr(OFS_VAL_LO, 32'h00000005);
    tick(16'h0003, 1'b1);
    rd("pwm_held", OFS_VAL_LO, 8'h02);
    tick(16'h000F, 1'b1);
    rd("pwm_moved", OFS_VAL_LO, 8'h05);
    tick(16'h0010, 1'b1);
    pin_is(1'b1);
    tick(16'h0005, 1'b1);
    pin_is(1'b0);
    wr(OFS_CTRL, ctl(4'h9));
    tick(16'h0010, 1'b1);
    pin_is(1'b0);
    tick(16'h0005, 1'b1);
    pin_is(1'b1);
    wr(OFS_GLOBAL, 32'h00000003);
    wr(OFS_CTRL, ctl(4'h2));
    chk("cas", 32'h1, {31'h0, cas});
    tick(16'h0005, 1'b1);
    pin_is(1'b0);
    wr(OFS_CTRL, ctl(4'h1));
    tick(16'h0005, 1'b0);
    pin_is(1'b0);
    tick(16'h0005, 1'b1);
    pin_is(1'b1);
    modulo <= 16'h0000;
    wr(OFS_VAL_HI, 32'h00000000);
    wr(OFS_VAL_LO, 32'h00000007);
    tick(16'hFFFE, 1'b0);
    rd("free_held", OFS_VAL_LO, 8'h05);
    tick(16'hFFFE, 1'b1);
    rd("free_moved", OFS_VAL_LO, 8'h07);
    $display("pwm test done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_capture();
    t_compare();
    t_debug();
    t_clocked();
    t_pwm();
    give_verdict();
  end
endmodule

// ---- testbench/timer_pin_model.sv ----
module timer_pin_model
(
  input  wire logic level_req_i, // Level the outside circuit drives
  input  wire logic timer_drv_i, // Timer drive value
  input  wire logic timer_oe_i,  // Timer owns the pin
  output logic      pin_level_o  // Resolved pin level
);
  timeunit 1ns;
  timeprecision 1ps;

  // Outside circuit yields to the timer while it drives; the bench only
  // moves level_req_i at clock edges, so it stays put around mode changes
  assign pin_level_o = timer_oe_i ? timer_drv_i : level_req_i;
endmodule
